// [fmu_unit.sv]
/*
  Negated fused multiply-add / multiply-subtract in single, double and
  paired-single formats, plus two paired-single merges, with an APB
  register slave holding rounding mode, exception bits and interrupts.
  Assumes a register file with same-cycle combinational reads and an
  issue stage on the same clock that holds a request until op_ready.
*/
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RQ1: negated multiply-add rounds first*second+addend once, then negates.
// RQ2: negated multiply-subtract rounds first*second-addend, then negates.
// RQ3: negation only inverts the sign bit of the rounded value.
// RQ4: the format field selects single, double or paired for all operands.
// RQ5: paired format works each half alone and ORs their exceptions.
// RQ6: with no exception taken, fresh cause bits are ORed into the flags.
// RQ7: only inexact, unimplemented, invalid, overflow, underflow may arise.
// RQ8: only coprocessor-unusable and reserved-instruction traps are raised.
// RQ9: a register field invalid for the format gives an undefined result.
// RQ10: a source not in the format leaves result and operands undefined.
// RQ11: paired operations in 16-register mode give an undefined result.
// RQ12: low-low merge packs first bits 31..0 above second bits 31..0.
// RQ13: low-high merge packs first bits 31..0 above second bits 63..32.
// RQ14: merges raise nothing and leave cause and flag bits unchanged.
// RQ15: merge register fields must be valid paired registers.
// RQ16: one operation per issue, written back to the register file.
// RQ17: undefined cases never hang, touch other registers or trap oddly.
module fmu_unit
  import fmu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic cu1_enable,
  input wire logic fp64_reg_mode,
  input wire logic op_valid,
  output logic op_ready,
  input wire fmu_op_t op_sel,
  input wire logic [2:0] op_fmt,
  input wire logic [4:0] addend_reg_field,
  input wire logic [4:0] first_source_reg_field,
  input wire logic [4:0] second_source_reg_field,
  input wire logic [4:0] dest_reg_field,
  output logic [4:0] rf_raddr_addend,
  output logic [4:0] rf_raddr_first,
  output logic [4:0] rf_raddr_second,
  input wire logic [63:0] rf_rdata_addend,
  input wire logic [63:0] rf_rdata_first,
  input wire logic [63:0] rf_rdata_second,
  output logic rf_we,
  output logic [4:0] rf_waddr,
  output logic [63:0] rf_wdata,
  output logic exc_cop_unusable,
  output logic exc_reserved,
  output logic exc_fp_trap
);

  function automatic logic [63:0] fmu_pack(input logic dbl, input logic s,
                                           input logic [10:0] e,
                                           input logic [51:0] f);
    return dbl ? {s, e, f} : {32'h0, s, e[7:0], f[22:0]};
  endfunction

  function automatic fmu_val_t fmu_unpack(input logic [63:0] v,
                                          input logic dbl);
    fmu_val_t r;
    logic [51:0] f;
    logic [10:0] emax;
    emax = dbl ? EMAX_D : EMAX_S;
    r.s = dbl ? v[63] : v[31];
    r.e = dbl ? v[62:52] : {3'h0, v[30:23]};
    f = dbl ? v[51:0] : {29'h0, v[22:0]};
    r.m = {1'b0, f};
    if (r.e != 11'h0) begin
      r.m[dbl ? MB_D : MB_S] = 1'b1;
    end
    r.nan = (r.e == emax) && (f != 52'h0);
    r.snan = r.nan && !f[dbl ? MB_D - 1 : MB_S - 1];
    r.inf = (r.e == emax) && (f == 52'h0);
    r.den = (r.e == 11'h0) && (f != 52'h0);
    r.zero = (r.e == 11'h0) && (f == 52'h0);
    return r;
  endfunction

  // right shift that folds every lost bit into bit 0
  function automatic logic [FRAME_W-1:0] fmu_shr(input logic [FRAME_W-1:0] x,
                                                 input int n);
    logic [FRAME_W-1:0] lost;
    if (n >= FRAME_W) begin
      return FRAME_W'(|x);
    end
    lost = x & ~({FRAME_W{1'b1}} << n);
    return (x >> n) | FRAME_W'(|lost);
  endfunction

  // one lane: returns {cause, result}
  function automatic logic [69:0] fmu_fma(input logic [63:0] va,
                                          input logic [63:0] vb,
                                          input logic [63:0] vc,
                                          input logic dbl,
                                          input logic sub,
                                          input logic [1:0] rm);
    fmu_val_t a;
    fmu_val_t b;
    fmu_val_t c;
    logic [105:0] p;
    logic [FRAME_W-1:0] pf;
    logic [FRAME_W-1:0] af;
    logic [FRAME_W-1:0] mag;
    logic [FRAME_W-1:0] norm;
    logic [52:0] frac;
    logic [63:0] res;
    logic [5:0] cs;
    logic sp;
    logic sr;
    logic sg;
    logic rb;
    logic st;
    logic inc;
    logic pinf;
    logic pzero;
    logic to_max;
    int mbits;
    int emax;
    int bias;
    int lp;
    int la;
    int base;
    int k;
    int ex;
    a = fmu_unpack(va, dbl);
    b = fmu_unpack(vb, dbl);
    c = fmu_unpack(vc, dbl);
    mbits = dbl ? MB_D : MB_S;
    emax = dbl ? int'(EMAX_D) : int'(EMAX_S);
    bias = dbl ? BIAS_D : BIAS_S;
    sp = b.s ^ c.s;
    sr = a.s ^ sub; // RQ2
    sg = sp;
    cs = 6'h00;
    k = 0;
    p = b.m * c.m; // RQ1
    pf = FRAME_W'(p) << GUARD;
    af = FRAME_W'(a.m) << ADD_SHIFT;
    lp = int'(b.e) + int'(c.e) - bias - 2 * mbits - GUARD;
    la = int'(a.e) - mbits - ADD_SHIFT;
    if (la >= lp) begin
      base = la;
      pf = fmu_shr(pf, la - lp);
    end else begin
      base = lp;
      af = fmu_shr(af, lp - la);
    end
    if (sp == sr) begin
      mag = pf + af;
    end else if (pf >= af) begin
      mag = pf - af;
    end else begin
      mag = af - pf;
      sg = sr;
    end
    for (int i = 0; i < FRAME_W; i++) begin
      if (mag[i]) begin
        k = i;
      end
    end
    ex = base + k;
    norm = mag << (FRAME_W - 1 - k);
    if (dbl) begin
      frac = {1'b0, norm[FRAME_W-2 -: MB_D]};
      rb = norm[FRAME_W-2-MB_D];
      st = |norm[FRAME_W-3-MB_D:0];
    end else begin
      frac = {30'h0, norm[FRAME_W-2 -: MB_S]};
      rb = norm[FRAME_W-2-MB_S];
      st = |norm[FRAME_W-3-MB_S:0];
    end
    case (rm) // RQ1
      RM_NEAREST: inc = rb & (st | frac[0]);
      RM_ZERO: inc = 1'b0;
      RM_PLUS: inc = (rb | st) & !sg;
      default: inc = (rb | st) & sg;
    endcase
    frac = frac + 53'(inc);
    if (frac[mbits]) begin
      ex = ex + 1;
      frac = 53'h0;
    end
    to_max = (rm == RM_ZERO) || (rm == RM_PLUS && sg) ||
             (rm == RM_MINUS && !sg);
    pinf = b.inf | c.inf;
    pzero = b.zero | c.zero;
    // each result other than NaN or unimplemented inverts only the sign of the rounded value
    if (a.den | b.den | c.den) begin
      cs[C_UNIMPL] = 1'b1; // RQ7
      res = 64'h0;
    end else if (a.nan | b.nan | c.nan | (pinf & pzero) |
                 (pinf & a.inf & (sp != sr))) begin
      cs[C_INVALID] = a.snan | b.snan | c.snan | (pinf & pzero) |
                      (pinf & a.inf & !a.nan & !b.nan & !c.nan); // RQ7
      res = dbl ? NAN_D : {32'h0, NAN_S};
    end else if (pinf | a.inf) begin
      res = fmu_pack(dbl, !(pinf ? sp : sr), 11'(emax), 52'h0); // RQ3
    end else if (mag == '0) begin
      res = fmu_pack(dbl, !((sp == sr) ? sp : (rm == RM_MINUS)),
                     11'h0, 52'h0); // RQ3
    end else if (base + k <= 0) begin
      cs[C_UNIMPL] = 1'b1; // RQ7
      res = 64'h0;
    end else if (ex >= emax) begin
      cs[C_OVER] = 1'b1; // RQ7
      cs[C_INEXACT] = 1'b1;
      res = to_max ? fmu_pack(dbl, !sg, 11'(emax - 1), {52{1'b1}})
                   : fmu_pack(dbl, !sg, 11'(emax), 52'h0); // RQ3
    end else begin
      cs[C_INEXACT] = rb | st; // RQ7
      res = fmu_pack(dbl, !sg, 11'(ex), frac[51:0]); // RQ3
    end
    return {cs, res};
  endfunction

  logic [1:0] csr_rm;
  logic [4:0] csr_flags;
  logic [4:0] csr_en;
  logic [5:0] csr_cause;
  logic [3:0] int_stat;
  logic [3:0] int_mask;
  logic s1_valid;
  fmu_op_t s1_op;
  logic [2:0] s1_fmt;
  logic [4:0] s1_dst;
  logic [63:0] s1_a;
  logic [63:0] s1_b;
  logic [63:0] s1_c;
  logic s1_ps16;
  logic wb_arith;
  logic csr_wr_q;
  logic [69:0] lane_lo;
  logic [69:0] lane_hi;
  logic [63:0] next_res;
  logic [5:0] next_cause;
  logic take;
  logic op_arith;
  logic op_legal;
  logic s1_arith;
  logic trap;
  logic apb_wr;
  logic apb_hit;
  logic csr_wr;
  logic [31:0] next_rdata;

  // register reads go straight through; invalid names are not checked
  assign rf_raddr_addend = addend_reg_field; // RQ9
  assign rf_raddr_first = first_source_reg_field; // RQ15
  assign rf_raddr_second = second_source_reg_field;

  assign op_ready = !s1_valid; // RQ16
  assign take = op_valid && op_ready;
  assign op_arith = (op_sel == neg_mul_add_op) || (op_sel == neg_mul_sub_op);
  assign op_legal = !op_arith || op_fmt == FMT_SINGLE ||
                    op_fmt == FMT_DOUBLE || op_fmt == FMT_PAIRED; // RQ4
  assign s1_arith = (s1_op == neg_mul_add_op) || (s1_op == neg_mul_sub_op);

  // low lane serves single and double; high lane only paired
  assign lane_lo = fmu_fma(s1_a, s1_b, s1_c, s1_fmt == FMT_DOUBLE,
                           s1_op == neg_mul_sub_op, csr_rm); // RQ4
  assign lane_hi = fmu_fma({32'h0, s1_a[63:32]}, {32'h0, s1_b[63:32]},
                           {32'h0, s1_c[63:32]}, 1'b0,
                           s1_op == neg_mul_sub_op, csr_rm); // RQ5

  always_comb begin
    next_res = 64'h0;
    next_cause = 6'h00;
    unique case (s1_op)
      neg_mul_add_op, neg_mul_sub_op: begin
        if (s1_fmt == FMT_PAIRED) begin
          next_res = {lane_hi[31:0], lane_lo[31:0]}; // RQ5
          next_cause = lane_hi[69:64] | lane_lo[69:64]; // RQ5
        end else begin
          next_res = lane_lo[63:0];
          next_cause = lane_lo[69:64];
        end
      end
      pair_merge_low_low: next_res = {s1_b[31:0], s1_c[31:0]}; // RQ12
      pair_merge_low_high: next_res = {s1_b[31:0], s1_c[63:32]}; // RQ13
    endcase
    if (s1_ps16) begin
      next_res = 64'h0; // RQ11
      next_cause = 6'h00;
    end
  end

  // unimplemented always traps; the rest only when enabled
  assign trap = s1_valid && s1_arith &&
                |(next_cause & {1'b1, csr_en});

  // issue stage: operands are taken as read, never checked for format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid <= 1'b0;
      s1_op <= neg_mul_add_op;
      s1_fmt <= FMT_SINGLE;
      s1_dst <= 5'h00;
      s1_a <= 64'h0;
      s1_b <= 64'h0;
      s1_c <= 64'h0;
      s1_ps16 <= 1'b0;
      exc_cop_unusable <= 1'b0;
      exc_reserved <= 1'b0;
    end else begin
      s1_valid <= take && cu1_enable && op_legal; // RQ16
      exc_cop_unusable <= take && !cu1_enable; // RQ8
      exc_reserved <= take && cu1_enable && !op_legal; // RQ8
      if (take) begin
        s1_op <= op_sel;
        s1_fmt <= op_fmt;
        s1_dst <= dest_reg_field;
        s1_a <= rf_rdata_addend; // RQ10
        s1_b <= rf_rdata_first;
        s1_c <= rf_rdata_second;
        s1_ps16 <= !fp64_reg_mode &&
                   (!op_arith || op_fmt == FMT_PAIRED); // RQ11
      end
    end
  end

  // writeback touches only the named destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_we <= 1'b0;
      rf_waddr <= 5'h00;
      rf_wdata <= 64'h0;
      exc_fp_trap <= 1'b0;
      wb_arith <= 1'b0;
    end else begin
      rf_we <= s1_valid && !trap; // RQ16
      exc_fp_trap <= trap; // RQ6
      wb_arith <= s1_valid && s1_arith && !s1_ps16;
      if (s1_valid) begin
        rf_waddr <= s1_dst; // RQ17
        rf_wdata <= next_res;
      end
    end
  end

  assign apb_wr = psel && penable && pwrite;
  assign apb_hit = paddr == ADDR_CSR || paddr == ADDR_INT_STAT ||
                   paddr == ADDR_INT_MASK || paddr == ADDR_INFO;
  assign csr_wr = apb_wr && paddr == ADDR_CSR;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign irq = |(int_stat & int_mask);

  // control/status register; hardware cause updates win over software, hardware flag bits are ORed into a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_rm <= RM_RESET;
      csr_flags <= FLAG_RESET;
      csr_en <= EN_RESET;
      csr_cause <= CAUSE_RESET;
      csr_wr_q <= 1'b0;
    end else begin
      csr_wr_q <= csr_wr;
      if (csr_wr) begin
        csr_rm <= pwdata[RM_LSB +: 2];
        csr_en <= pwdata[EN_LSB +: 5];
      end
      if (s1_valid && s1_arith && !s1_ps16) begin
        csr_cause <= next_cause; // RQ6
      end else if (csr_wr) begin
        csr_cause <= pwdata[CAUSE_LSB +: 6]; // RQ14
      end
      if (s1_valid && s1_arith && !s1_ps16 && !trap) begin
        csr_flags <= (csr_wr ? pwdata[FLAG_LSB +: 5] : csr_flags) |
                     next_cause[4:0]; // RQ6
      end else if (csr_wr) begin
        csr_flags <= pwdata[FLAG_LSB +: 5];
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= INT_RESET;
      int_mask <= INT_RESET;
    end else begin
      int_stat <= (int_stat & ~((apb_wr && paddr == ADDR_INT_STAT) ?
                   pwdata[3:0] : 4'h0)) |
                  {exc_reserved, exc_cop_unusable, exc_fp_trap, rf_we};
      if (apb_wr && paddr == ADDR_INT_MASK) begin
        int_mask <= pwdata[3:0];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    unique case (paddr)
      ADDR_CSR: begin
        next_rdata[RM_LSB +: 2] = csr_rm;
        next_rdata[FLAG_LSB +: 5] = csr_flags;
        next_rdata[EN_LSB +: 5] = csr_en;
        next_rdata[CAUSE_LSB +: 6] = csr_cause;
      end
      ADDR_INT_STAT: next_rdata[3:0] = int_stat;
      ADDR_INT_MASK: next_rdata[3:0] = int_mask;
      ADDR_INFO: next_rdata[5:0] = {s1_valid, rf_waddr};
      default: next_rdata = 32'h0;
    endcase
  end

  // read data is latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take_arith;
    take && cu1_enable && op_arith && op_legal;
  endsequence
  sequence s_take_merge;
    take && cu1_enable && !op_arith;
  endsequence

  chk_issue_wb: assert property (s_take_arith |-> ##2 (rf_we ^ exc_fp_trap)) // RQ16
    else $error("arithmetic issue gave no single completion");
  chk_merge_dest: assert property (s_take_merge |-> ##2 (rf_we && // RQ16
      rf_waddr == $past(dest_reg_field, 2)))
    else $error("merge did not write its destination");
  chk_cop_unusable: assert property (take && !cu1_enable |=> // RQ8
      exc_cop_unusable && !s1_valid ##1 !rf_we)
    else $error("unusable coprocessor still ran");
  chk_merge_low_low: assert property (s1_valid && !s1_ps16 && // RQ12
      s1_op == pair_merge_low_low |=>
      rf_wdata == {$past(s1_b[31:0]), $past(s1_c[31:0])})
    else $error("low-low merge data wrong");
  chk_merge_low_high: assert property (s1_valid && !s1_ps16 && // RQ13
      s1_op == pair_merge_low_high |=>
      rf_wdata == {$past(s1_b[31:0]), $past(s1_c[63:32])})
    else $error("low-high merge data wrong");
  chk_merge_keeps: assert property (s1_valid && !s1_arith && !csr_wr // RQ14
      |=> $stable(csr_cause) && $stable(csr_flags))
    else $error("merge changed exception bits");
  chk_flag_accum: assert property (rf_we && wb_arith && !csr_wr_q |-> // RQ6
      csr_flags == ($past(csr_flags) | csr_cause[4:0]))
    else $error("flags not accumulated from cause");
  chk_trap_holds: assert property (exc_fp_trap && !csr_wr_q |-> // RQ6
      $stable(csr_flags) && !rf_we)
    else $error("trap wrote result or flags");
  chk_cause_set: assert property ((rf_we || exc_fp_trap) && wb_arith && // RQ7
      !csr_wr_q |-> !csr_cause[C_DIVZ])
    else $error("disallowed exception cause raised");
  chk_ps16_zero: assert property (s1_valid && s1_ps16 |=> // RQ11
      rf_we && rf_wdata == 64'h0 && !exc_fp_trap)
    else $error("paired op in 16-register mode misbehaved");
endmodule
`default_nettype wire

// [fmu_pkg.sv]
/*
  Shared constants and types for the negated fused multiply-add and
  paired-single merge unit: register offsets, control/status register
  fields, exception cause positions, formats, operations, frame sizes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fmu_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CSR = 8'h00;
  localparam logic [7:0] ADDR_INT_STAT = 8'h04;
  localparam logic [7:0] ADDR_INT_MASK = 8'h08;
  localparam logic [7:0] ADDR_INFO = 8'h0C;
  // control/status register layout
  localparam int RM_LSB = 0;
  localparam int FLAG_LSB = 2;
  localparam int EN_LSB = 7;
  localparam int CAUSE_LSB = 12;
  localparam logic [1:0] RM_RESET = 2'h0;
  localparam logic [4:0] FLAG_RESET = 5'h00;
  localparam logic [4:0] EN_RESET = 5'h00;
  localparam logic [5:0] CAUSE_RESET = 6'h00;
  localparam logic [3:0] INT_RESET = 4'h0;
  // cause bit positions
  localparam int C_INEXACT = 0;
  localparam int C_UNDER = 1;
  localparam int C_OVER = 2;
  localparam int C_DIVZ = 3;
  localparam int C_INVALID = 4;
  localparam int C_UNIMPL = 5;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRAP = 1;
  localparam int IRQ_COPU = 2;
  localparam int IRQ_RSVD = 3;
  // rounding modes
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_PLUS = 2'h2;
  localparam logic [1:0] RM_MINUS = 2'h3;
  // operand formats
  localparam logic [2:0] FMT_SINGLE = 3'h0;
  localparam logic [2:0] FMT_DOUBLE = 3'h1;
  localparam logic [2:0] FMT_PAIRED = 3'h6;
  // number layout
  localparam int MB_D = 52;
  localparam int MB_S = 23;
  localparam int BIAS_D = 1023;
  localparam int BIAS_S = 127;
  localparam logic [10:0] EMAX_D = 11'h7FF;
  localparam logic [10:0] EMAX_S = 11'h0FF;
  localparam logic [63:0] NAN_D = 64'h7FF8_0000_0000_0000;
  localparam logic [31:0] NAN_S = 32'h7FC0_0000;
  // exact-sum frame
  localparam int FRAME_W = 176;
  localparam int GUARD = 3;
  localparam int ADD_SHIFT = 55;

  typedef enum logic [1:0] {
    neg_mul_add_op = 2'b00,
    neg_mul_sub_op = 2'b01,
    pair_merge_low_low = 2'b10,
    pair_merge_low_high = 2'b11
  } fmu_op_t;

  typedef struct packed {
    logic s;
    logic [10:0] e;
    logic [52:0] m;
    logic nan;
    logic snan;
    logic inf;
    logic den;
    logic zero;
  } fmu_val_t;
endpackage
`default_nettype wire

// [fmu_rf_model.sv]
/*
  Floating-point register file model facing the unit: 32 words of 64 bits,
  same-cycle reads, write-back on rf_we, and a bench load port.
  Assumes one clock shared with the unit.
*/
`timescale 1ns/100ps
`default_nettype none
module fmu_rf_model (
  input wire logic pclk,
  input wire logic [4:0] ra_a,
  input wire logic [4:0] ra_b,
  input wire logic [4:0] ra_c,
  output logic [63:0] rd_a,
  output logic [63:0] rd_b,
  output logic [63:0] rd_c,
  input wire logic we,
  input wire logic [4:0] wa,
  input wire logic [63:0] wd,
  input wire logic ld_en,
  input wire logic [4:0] ld_addr,
  input wire logic [63:0] ld_data
);
  logic [63:0] mem [32];
  // bench preload, then unit write-back
  always_ff @(posedge pclk) begin
    if (ld_en) mem[ld_addr] <= ld_data;
    else if (we) mem[wa] <= wd;
  end
  assign rd_a = mem[ra_a];
  assign rd_b = mem[ra_b];
  assign rd_c = mem[ra_c];
endmodule
`default_nettype wire

// [fp_neg_fused_madd_pair_merge_tb_top.sv]
/*
  Self-checking bench for fmu_unit: APB master, issue driver, queue
  of expected write-backs checked by a monitor. Assumes fmu_rf_model.
*/
`timescale 1ns/100ps
`default_nettype none
module fp_neg_fused_madd_pair_merge_tb_top;
  import fmu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, irq, e, op_ready, rf_we;
  logic cu1_enable = 1, fp64_reg_mode = 1, op_valid = 0, ld_en = 0;
  fmu_op_t op_sel = neg_mul_add_op;
  logic [2:0] op_fmt = 0;
  logic [4:0] fa = 0, fb = 0, fc = 0, fdst = 0, ra, rb, rc, rf_waddr;
  logic [4:0] ld_addr = 0;
  logic [63:0] da, db, dc, rf_wdata, ld_data = 0, m10, m11;
  logic exc_cu, exc_rs, exc_tr;
  logic [68:0] exp_q [$];
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 72581;
  logic [31:0] rx [4] = '{32'hBF800000, 32'hBF800000, 32'hBF800001,
                          32'hBF800000};
  always #2.5 pclk = ~pclk;
  fmu_unit i_fmu_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .cu1_enable(cu1_enable), .fp64_reg_mode(fp64_reg_mode),
    .op_valid(op_valid), .op_ready(op_ready), .op_sel(op_sel),
    .op_fmt(op_fmt), .addend_reg_field(fa),
    .first_source_reg_field(fb), .second_source_reg_field(fc),
    .dest_reg_field(fdst), .rf_raddr_addend(ra), .rf_raddr_first(rb),
    .rf_raddr_second(rc), .rf_rdata_addend(da), .rf_rdata_first(db),
    .rf_rdata_second(dc), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .exc_cop_unusable(exc_cu),
    .exc_reserved(exc_rs), .exc_fp_trap(exc_tr));
  fmu_rf_model i_fmu_rf_model (.pclk(pclk), .ra_a(ra), .ra_b(rb),
    .ra_c(rc), .rd_a(da), .rd_b(db), .rd_c(dc), .we(rf_we),
    .wa(rf_waddr), .wd(rf_wdata), .ld_en(ld_en), .ld_addr(ld_addr),
    .ld_data(ld_data));
  task chk(input string n, input logic [68:0] x, input logic [68:0] g);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task ld(input logic [4:0] a, input logic [63:0] d);
    @(posedge pclk);
    ld_en <= 1;
    ld_addr <= a;
    ld_data <= d;
    @(posedge pclk);
    ld_en <= 0;
  endtask
  // k: 0 write-back expected, 1 unusable trap, 2 reserved trap, 3 fp trap
  task op(input fmu_op_t s, input logic [2:0] f, input logic [4:0] a, b,
          c, d, input logic [63:0] x, input int k);
    @(posedge pclk);
    op_sel <= s;
    op_fmt <= f;
    fa <= a;
    fb <= b;
    fc <= c;
    fdst <= d;
    op_valid <= 1;
    do @(negedge pclk); while (op_ready !== 1'b1);
    if (k == 0) exp_q.push_back({d, x});
    @(posedge pclk);
    op_valid <= 0;
    @(negedge pclk);
    if (k == 1) chk("exc_cu", 1, exc_cu);
    if (k == 2) chk("exc_rs", 1, exc_rs);
    if (k == 3) begin
      @(negedge pclk);
      chk("exc_tr", 1, exc_tr);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done;
    end
    if (presetn && rf_we === 1'b1 && exp_q.size() > 0)
      chk("writeback", exp_q.pop_front(), {rf_waddr, rf_wdata});
    else if (presetn && rf_we === 1'b1) begin
      n_errors++;
      $display("[FAIL] writeback expected none seen %h", rf_waddr);
    end
  end
  initial begin
    m10 = {$random(seed), $random(seed)};
    m11 = {$random(seed), $random(seed)};
    repeat (5) @(posedge pclk);
    presetn <= 1;
    ld(1, 64'h3F800000);
    ld(2, 64'h40000000);
    ld(3, 64'h30800000);
    ld(4, 64'h4000000000000000);
    ld(5, 64'h4008000000000000);
    ld(6, 64'h3FF0000000000000);
    ld(7, 64'h400000003F800000);
    ld(8, 64'h3F80000040000000);
    ld(10, m10);
    ld(11, m11);
    apb(0, ADDR_CSR, 0);
    chk("csr_reset", 0, q);
    apb(0, 8'h10, 0);
    chk("bad_err", 1, e);
    op(neg_mul_add_op, FMT_SINGLE, 1, 1, 2, 20, 64'hC0400000, 0);
    op(neg_mul_sub_op, FMT_DOUBLE, 6, 4, 5, 21, 64'hC014 << 48, 0);
    op(neg_mul_add_op, FMT_PAIRED, 8, 7, 8, 22, 64'hC0400000C0800000,
       0);
    for (int r = 0; r < 4; r++) begin
      apb(1, ADDR_CSR, r);
      op(neg_mul_add_op, FMT_SINGLE, 3, 1, 1, 23, {32'h0, rx[r]}, 0);
      apb(0, ADDR_CSR, 0);
      chk("csr_flags", r | 32'h1004, q);
    end
    op(pair_merge_low_low, FMT_PAIRED, 0, 10, 11, 24,
       {m10[31:0], m11[31:0]}, 0);
    op(pair_merge_low_high, FMT_PAIRED, 0, 10, 11, 25,
       {m10[31:0], m11[63:32]}, 0);
    apb(0, ADDR_CSR, 0);
    chk("csr_merge", 32'h1007, q);
    apb(1, ADDR_CSR, 32'h80);
    op(neg_mul_add_op, FMT_SINGLE, 3, 1, 1, 28, 0, 3);
    apb(0, ADDR_CSR, 0);
    chk("csr_trap", 32'h1080, q);
    @(posedge pclk);
    fp64_reg_mode <= 0;
    op(pair_merge_low_low, FMT_PAIRED, 0, 10, 11, 26, 0, 0);
    @(posedge pclk);
    fp64_reg_mode <= 1;
    cu1_enable <= 0;
    op(neg_mul_add_op, FMT_SINGLE, 1, 1, 2, 27, 0, 1);
    @(posedge pclk);
    cu1_enable <= 1;
    op(neg_mul_sub_op, 3'h2, 1, 1, 2, 27, 0, 2);
    apb(0, ADDR_INT_STAT, 0);
    chk("int_stat", 32'hF, q);
    apb(1, ADDR_INT_MASK, 1);
    repeat (2) @(negedge pclk);
    chk("irq_on", 1, irq);
    apb(1, ADDR_INT_STAT, 1);
    repeat (2) @(negedge pclk);
    chk("irq_off", 0, irq);
    apb(0, ADDR_INT_STAT, 0);
    chk("int_w1c", 32'hE, q);
    chk("wb_left", 0, exp_q.size());
    test_done;
  end
endmodule
`default_nettype wire
